// *** verilog/fts_top.sv ***
// Fork and thread scheduler of one CPU with Avalon-MM register access
//
// How it works
// R1: Idle scan binds CPU, copying fork state
// R2: Single fork cleared on accept; multi stays
// R3: Clear-fork drops any posted fork, no thread
// R4: Terminate-and-wait ends thread, idles, scans onward
// R5: Join: non-final idles, final continues single
// R6: First join marks fork type halted
// R7: Last thread's join clears the fork
// R8: New thread gets vector valid flag cleared
// R9: Move copies set index into result
// R10: Move loads set index, switching immediately
// R11: Load fills selected set from memory
// R12: Store writes selected set to memory
// R13: Idle op forces scan, ring 0 only
// R14: Unreceivable thread count makes acceptance fail
// R15: Software checks single fork before terminating
// R16: Spawned region must work for any threads
// R17: Accept checks posted lock, then top lock
// R18: Create takes lowest mask bit, counts up
// R19: Thread count kept between zero and 32
// R20: Post fails with carry clear if locked
// R21: Undefined lock pair skipped by scan
// R22: Interrupts checked between set scans
//
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module fts_top
  import fts_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic irq_pending,
  output logic irq_taken,
  output logic cpu_idle
);

  // ********************************
  // Helpers
  // ********************************
  function automatic logic [4:0] lowest_set(input logic [31:0] m);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (m[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ALLOC is the only state with bit 0 clear, so one flop bit says idle
  function automatic logic is_idle(input fts_state_e s);
    return s[0];
  endfunction

  // Posted lock first, then top lock; the 0/1 pair is never taken
  function automatic logic offered(input fts_set_s s);
    return s.posted && s.lck && s.ftype != FTS_HALTED_FORK_CODE; // [R17] [R21]
  endfunction

  // Blocked count, empty mask or full count makes acceptance fail
  function automatic logic has_room(input fts_set_s s);
    return !s.unrecv && s.mask != 32'h00000000 && s.count < FTS_COUNT_MAX; // [R14] [R19]
  endfunction

  function automatic fts_regs_s reset_state();
    fts_regs_s s;
    s = '0;
    for (int i = 0; i < FTS_NSETS; i++) begin
      s.sets[i].mask = FTS_MASK_RST;
      s.save[i].mask = FTS_MASK_RST;
    end
    // Set 0 already holds the running thread 0
    s.sets[0].mask = FTS_MASK_RST_SET0;
    s.sets[0].count = FTS_COUNT_RST_SET0;
    s.st = FTS_ALLOC;
    s.ring = FTS_RING_RST;
    s.wait_rq = 1'b1;
    return s;
  endfunction

  // ********************************
  // State
  // ********************************
  fts_regs_s r_reg;
  fts_regs_s r_next;
  logic bus_go;
  logic [2:0] k_idx;
  fts_set_s cur;
  fts_set_s probe;
  logic [4:0] pick;

  assign bus_go = (avs_read || avs_write) && !r_reg.wait_rq;
  assign k_idx = r_reg.opnd[2:0];
  assign cur = r_reg.sets[r_reg.comm_set_index_reg];
  assign probe = r_reg.sets[r_reg.scan];
  assign pick = lowest_set(probe.mask);

  always_comb begin
    r_next = r_reg;
    r_next.irq_ack = 1'b0;

    // Pin input: filtered level changes only once stages two and three agree
    r_next.sy = {r_reg.sy[1:0], irq_pending};
    if (r_reg.sy[1] == r_reg.sy[2]) begin
      r_next.irq_lvl = r_reg.sy[2];
    end

    // ********************************
    // Idle search loop
    // ********************************
    unique case (r_reg.st)
      FTS_ALLOC: begin
      end
      FTS_SCAN: begin
        r_next.st = FTS_INTR_CHK;
        // Posted lock must be set before the top lock counts [R17]
        // Lock pair 0/1 is undefined and never accepted [R21]
        if (offered(probe)) begin
          // Blocked count or empty mask: acceptance fails, fork untouched [R14]
          if (has_room(probe)) begin
            r_next.comm_set_index_reg = r_reg.scan; // [R1]
            r_next.pc = probe.pc; // [R1]
            r_next.sp = probe.sp; // [R1]
            r_next.vv = 1'b0; // [R8]
            r_next.thread_index_reg = pick; // [R18]
            r_next.sets[r_reg.scan].mask[pick] = 1'b0; // [R18]
            r_next.sets[r_reg.scan].count = probe.count + 6'h01; // [R18] [R19]
            if (probe.ftype == FTS_SINGLE_FORK_CODE) begin
              r_next.sets[r_reg.scan].posted = 1'b0; // [R2]
              r_next.sets[r_reg.scan].lck = 1'b0; // [R2]
            end
            r_next.st = FTS_ALLOC;
          end
        end
      end
      FTS_INTR_CHK: begin
        // Idle CPUs stay reachable for interrupts between scans [R22]
        if (r_reg.irq_lvl) begin
          r_next.st = FTS_ALLOC;
          r_next.ring = FTS_RING_RST;
          r_next.irq_ack = 1'b1;
        end else begin
          r_next.scan = r_reg.scan + 3'h1;
          r_next.st = FTS_SCAN;
        end
      end
    endcase

    // ********************************
    // Instruction execution
    // ********************************
    if (r_reg.pend) begin
      r_next.pend = 1'b0;
      if (r_reg.st == FTS_ALLOC) begin
        unique case (r_reg.op)
          FTS_OP_PFORK, FTS_OP_SPAWN: begin
            if (cur.lck) begin
              r_next.carry = 1'b0; // [R20]
            end else begin
              r_next.sets[r_reg.comm_set_index_reg].lck = 1'b1;
              r_next.sets[r_reg.comm_set_index_reg].pc = r_reg.effa;
              r_next.sets[r_reg.comm_set_index_reg].sp = r_reg.opnd;
              r_next.sets[r_reg.comm_set_index_reg].ftype = (r_reg.op == FTS_OP_PFORK) ?
                FTS_SINGLE_FORK_CODE : FTS_MULTI_FORK_CODE;
              r_next.sets[r_reg.comm_set_index_reg].posted = 1'b1;
              r_next.carry = 1'b1;
            end
          end
          FTS_OP_CFORK: begin
            r_next.carry = cur.posted;
            if (cur.posted) begin
              r_next.sets[r_reg.comm_set_index_reg].posted = 1'b0; // [R3]
              r_next.sets[r_reg.comm_set_index_reg].lck = 1'b0; // [R3]
              r_next.sets[r_reg.comm_set_index_reg].ftype = FTS_TYPE_NONE; // [R3]
            end
          end
          FTS_OP_WFORK, FTS_OP_JOIN: begin
            // Count not receivable: retried in ALLOC, so interrupts wait until it clears
            if (cur.unrecv) begin
              r_next.pend = 1'b1;
            end else begin
              r_next.sets[r_reg.comm_set_index_reg].mask[r_reg.thread_index_reg] = 1'b1;
              if (cur.count != 6'h00) begin
                r_next.sets[r_reg.comm_set_index_reg].count = cur.count - 6'h01; // [R19]
              end
              if (r_reg.op == FTS_OP_WFORK || cur.count > 6'h01) begin
                if (r_reg.op == FTS_OP_JOIN) begin
                  r_next.sets[r_reg.comm_set_index_reg].ftype = FTS_HALTED_FORK_CODE; // [R6]
                end
                r_next.st = FTS_SCAN; // [R4] [R5]
                r_next.scan = r_reg.comm_set_index_reg + 3'h1; // [R4]
              end else if (r_reg.op == FTS_OP_JOIN) begin
                // Final thread keeps running as a single thread [R5]
                r_next.sets[r_reg.comm_set_index_reg].posted = 1'b0; // [R7]
                r_next.sets[r_reg.comm_set_index_reg].lck = 1'b0; // [R7]
                r_next.sets[r_reg.comm_set_index_reg].ftype = FTS_TYPE_NONE; // [R7]
              end else begin
                r_next.st = FTS_SCAN; // [R4]
                r_next.scan = r_reg.comm_set_index_reg + 3'h1; // [R4]
              end
            end
          end
          FTS_OP_MOV_FROM_CIR: begin
            r_next.result = {29'h00000000, r_reg.comm_set_index_reg}; // [R9]
          end
          FTS_OP_MOV_TO_CIR: begin
            r_next.comm_set_index_reg = k_idx; // [R10]
          end
          FTS_OP_LOAD_SET: begin
            r_next.sets[k_idx] = r_reg.save[r_reg.effa[2:0]]; // [R11]
          end
          FTS_OP_STORE_SET: begin
            r_next.save[r_reg.effa[2:0]] = r_reg.sets[k_idx]; // [R12]
          end
          FTS_OP_IDLE: begin
            if (r_reg.ring == FTS_RING_RST) begin
              r_next.st = FTS_SCAN; // [R13]
              r_next.scan = r_reg.comm_set_index_reg; // [R13]
            end else begin
              r_next.fault = 1'b1; // [R13]
            end
          end
          default: begin
            r_next.fault = 1'b1;
          end
        endcase
      end
    end

    // ********************************
    // Avalon-MM slave, one wait state per access
    // ********************************
    r_next.wait_rq = !((avs_read || avs_write) && r_reg.wait_rq);
    if (bus_go && avs_write) begin
      unique case (avs_address)
        FTS_OFS_CMD: begin
          // A command written while one is pending is dropped
          if (avs_byteenable[0] && !r_reg.pend) begin
            r_next.op = avs_writedata[3:0];
            r_next.pend = 1'b1;
            r_next.fault = 1'b0;
          end
        end
        FTS_OFS_EFFA: r_next.effa = merge(r_reg.effa, avs_writedata, avs_byteenable);
        FTS_OFS_OPND: r_next.opnd = merge(r_reg.opnd, avs_writedata, avs_byteenable);
        FTS_OFS_RING: begin
          if (avs_byteenable[0]) begin
            r_next.ring = avs_writedata[1:0];
          end
        end
        FTS_OFS_SET_SEL: begin
          if (avs_byteenable[0]) begin
            r_next.sel = avs_writedata[2:0];
          end
        end
        FTS_OFS_THR_MASK: begin
          r_next.sets[r_reg.sel].mask = merge(r_reg.sets[r_reg.sel].mask, avs_writedata,
                                              avs_byteenable);
        end
        FTS_OFS_THR_CTRL: begin
          if (avs_byteenable[0]) begin
            r_next.sets[r_reg.sel].unrecv = avs_writedata[0]; // [R14]
          end
        end
        default: begin
        end
      endcase
    end
    // Loaded on the first request cycle, so the word stands while waitrequest is low
    // Read value is the state one cycle before the handshake completes
    if (avs_read && r_reg.wait_rq) begin
      r_next.rdata = 32'h00000000;
      unique case (avs_address)
        FTS_OFS_CMD: r_next.rdata = {28'h0000000, r_reg.op};
        FTS_OFS_EFFA: r_next.rdata = r_reg.effa;
        FTS_OFS_OPND: r_next.rdata = r_reg.opnd;
        FTS_OFS_STATUS: begin
          r_next.rdata[FTS_ST_CARRY] = r_reg.carry;
          r_next.rdata[FTS_ST_IDLE] = is_idle(r_reg.st);
          r_next.rdata[FTS_ST_BUSY] = r_reg.pend;
          r_next.rdata[FTS_ST_FAULT] = r_reg.fault;
          r_next.rdata[FTS_ST_VV] = r_reg.vv;
          r_next.rdata[FTS_ST_TID +: 5] = r_reg.thread_index_reg;
          r_next.rdata[FTS_ST_CIR +: 3] = r_reg.comm_set_index_reg;
          r_next.rdata[FTS_ST_RING +: 2] = r_reg.ring;
        end
        FTS_OFS_RESULT: r_next.rdata = r_reg.result;
        FTS_OFS_CPU_PC: r_next.rdata = r_reg.pc;
        FTS_OFS_CPU_SP: r_next.rdata = r_reg.sp;
        FTS_OFS_RING: r_next.rdata = {30'h00000000, r_reg.ring};
        FTS_OFS_SET_SEL: r_next.rdata = {29'h00000000, r_reg.sel};
        FTS_OFS_THR_MASK: r_next.rdata = r_reg.sets[r_reg.sel].mask;
        FTS_OFS_THR_CTRL: r_next.rdata = {31'h00000000, r_reg.sets[r_reg.sel].unrecv};
        FTS_OFS_SET_VIEW: begin
          r_next.rdata[FTS_SV_LCK] = r_reg.sets[r_reg.sel].lck;
          r_next.rdata[FTS_SV_POSTED] = r_reg.sets[r_reg.sel].posted;
          r_next.rdata[FTS_SV_TYPE +: 2] = r_reg.sets[r_reg.sel].ftype;
          r_next.rdata[FTS_SV_UNRECV] = r_reg.sets[r_reg.sel].unrecv;
          r_next.rdata[FTS_SV_COUNT +: 6] = r_reg.sets[r_reg.sel].count;
        end
        default: r_next.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      r_reg <= reset_state();
    end else begin
      r_reg <= r_next;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  assign avs_readdata = r_reg.rdata;
  assign avs_waitrequest = r_reg.wait_rq;
  assign irq_taken = r_reg.irq_ack;
  // Idle level is one state bit, so it leaves a flop with no gate
  assign cpu_idle = is_idle(r_reg.st);

endmodule

`default_nettype wire

// *** verilog/fts_pkg.sv ***
// Constants and types shared by the fork and thread scheduler
package fts_pkg;

  // ********************************
  // Sizes and register offsets
  // ********************************
  localparam int FTS_NSETS = 8;
  localparam logic [7:0] FTS_OFS_CMD = 8'h00;
  localparam logic [7:0] FTS_OFS_EFFA = 8'h04;
  localparam logic [7:0] FTS_OFS_OPND = 8'h08;
  localparam logic [7:0] FTS_OFS_STATUS = 8'h0C;
  localparam logic [7:0] FTS_OFS_RESULT = 8'h10;
  localparam logic [7:0] FTS_OFS_CPU_PC = 8'h14;
  localparam logic [7:0] FTS_OFS_CPU_SP = 8'h18;
  localparam logic [7:0] FTS_OFS_RING = 8'h1C;
  localparam logic [7:0] FTS_OFS_SET_SEL = 8'h20;
  localparam logic [7:0] FTS_OFS_THR_MASK = 8'h24;
  localparam logic [7:0] FTS_OFS_THR_CTRL = 8'h28;
  localparam logic [7:0] FTS_OFS_SET_VIEW = 8'h2C;

  // ********************************
  // Field positions
  // ********************************
  localparam int FTS_ST_CARRY = 0;
  localparam int FTS_ST_IDLE = 1;
  localparam int FTS_ST_BUSY = 2;
  localparam int FTS_ST_FAULT = 3;
  localparam int FTS_ST_VV = 4;
  localparam int FTS_ST_TID = 8;
  localparam int FTS_ST_CIR = 16;
  localparam int FTS_ST_RING = 20;
  localparam int FTS_SV_LCK = 0;
  localparam int FTS_SV_POSTED = 1;
  localparam int FTS_SV_TYPE = 4;
  localparam int FTS_SV_UNRECV = 7;
  localparam int FTS_SV_COUNT = 8;

  // ********************************
  // Codes and reset values
  // ********************************
  localparam logic [1:0] FTS_TYPE_NONE = 2'h0;
  localparam logic [1:0] FTS_SINGLE_FORK_CODE = 2'h1;
  localparam logic [1:0] FTS_MULTI_FORK_CODE = 2'h2;
  localparam logic [1:0] FTS_HALTED_FORK_CODE = 2'h3;
  localparam logic [3:0] FTS_OP_PFORK = 4'h1;
  localparam logic [3:0] FTS_OP_SPAWN = 4'h2;
  localparam logic [3:0] FTS_OP_CFORK = 4'h3;
  localparam logic [3:0] FTS_OP_WFORK = 4'h4;
  localparam logic [3:0] FTS_OP_JOIN = 4'h5;
  localparam logic [3:0] FTS_OP_MOV_FROM_CIR = 4'h6;
  localparam logic [3:0] FTS_OP_MOV_TO_CIR = 4'h7;
  localparam logic [3:0] FTS_OP_LOAD_SET = 4'h8;
  localparam logic [3:0] FTS_OP_STORE_SET = 4'h9;
  localparam logic [3:0] FTS_OP_IDLE = 4'hA;
  localparam logic [31:0] FTS_MASK_RST = 32'hFFFFFFFF;
  localparam logic [31:0] FTS_MASK_RST_SET0 = 32'hFFFFFFFE;
  localparam logic [5:0] FTS_COUNT_MAX = 6'h20;
  localparam logic [5:0] FTS_COUNT_RST_SET0 = 6'h01;
  localparam logic [1:0] FTS_RING_RST = 2'h0;

  typedef enum logic [1:0] {
    FTS_ALLOC = 2'b00,
    FTS_SCAN = 2'b01,
    FTS_INTR_CHK = 2'b11
  } fts_state_e;

  typedef struct packed {
    logic lck;
    logic posted;
    logic [1:0] ftype;
    logic [31:0] pc;
    logic [31:0] sp;
    logic [31:0] mask;
    logic [5:0] count;
    logic unrecv;
  } fts_set_s;

  typedef struct packed {
    fts_set_s [FTS_NSETS-1:0] sets;
    fts_set_s [FTS_NSETS-1:0] save;
    fts_state_e st;
    logic [2:0] comm_set_index_reg;
    logic [2:0] scan;
    logic [4:0] thread_index_reg;
    logic [31:0] pc;
    logic [31:0] sp;
    logic vv;
    logic carry;
    logic fault;
    logic [1:0] ring;
    logic pend;
    logic [3:0] op;
    logic [31:0] effa;
    logic [31:0] opnd;
    logic [31:0] result;
    logic [2:0] sel;
    logic [2:0] sy;
    logic irq_lvl;
    logic irq_ack;
    logic wait_rq;
    logic [31:0] rdata;
  } fts_regs_s;

endpackage

// *** verif/fts_top_chk.sv ***
// Port assertions for the fork and thread scheduler
`timescale 1ns/1ns
`default_nettype none

module fts_top_chk
  import fts_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq_pending,
  input wire logic irq_taken,
  input wire logic cpu_idle
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  a_wait_drop: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("waitrequest late");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_wait_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("waitrequest dropped unasked");
  a_rdata_hold: assert property ($changed(avs_readdata) && $past(nrst)
    |-> $past(avs_read && avs_waitrequest)) else $error("read data moved");
  a_irq_from_idle: assert property (irq_taken |-> $past(cpu_idle) && !cpu_idle)
    else $error("interrupt taken outside idle");
  a_irq_pulse: assert property (irq_taken |=> !irq_taken) else $error("long irq pulse");
  a_irq_cause: assert property (irq_taken |-> $past(irq_pending, 3))
    else $error("interrupt taken without request");
  a_idle_by_cmd: assert property ($rose(cpu_idle) |-> $past(avs_write, 2)
    && $past(avs_address, 2) == FTS_OFS_CMD) else $error("idle without command");
  a_reset_state: assert property (disable iff (1'b0) !nrst
    |=> avs_waitrequest && !cpu_idle && !irq_taken && avs_readdata == 32'h0)
    else $error("bad reset state");
  c_irq: cover property (irq_taken);
  c_idle: cover property ($rose(cpu_idle));
  c_read: cover property (avs_read && !avs_waitrequest);
endmodule

bind fts_top fts_top_chk u_fts_top_chk (.sys_clk(sys_clk), .nrst(nrst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .irq_pending(irq_pending), .irq_taken(irq_taken), .cpu_idle(cpu_idle));
`default_nettype wire

// *** verif/fts_irq_src.sv ***
// Outside interrupt source facing the scheduler
`timescale 1ns/1ns
`default_nettype none

module fts_irq_src (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic raise,
  input wire logic irq_taken,
  output logic irq_pending
);
  // Level held until taken, so a busy CPU never loses it
  always_ff @(posedge sys_clk) begin
    if (!nrst || irq_taken) begin
      irq_pending <= 1'b0;
    end else if (raise) begin
      irq_pending <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** verif/fts_top_tb.sv ***
// Self-checking bench for the fork and thread scheduler
`timescale 1ns/1ns
`default_nettype none

module fts_top_tb;
  import fts_pkg::*;
  logic sys_clk, nrst, avs_read, avs_write, irq_req;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, v;
  logic [3:0] avs_byteenable;
  logic avs_waitrequest, irq_pending, irq_taken, cpu_idle;
  int fails, checks_done;

  fts_top u_fts_top (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq_pending(irq_pending),
    .irq_taken(irq_taken), .cpu_idle(cpu_idle));
  fts_irq_src u_fts_irq_src (.sys_clk(sys_clk), .nrst(nrst), .raise(irq_req),
    .irq_taken(irq_taken), .irq_pending(irq_pending));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ****
  // Tasks
  // ****
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Extra edge after release, so a strobe never toggles twice in one step
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    // No cycle count assumed: only the watchdog ends a stalled wait
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    // Read data taken at the very edge that sees waitrequest low
    if (!wr) begin
      v = avs_readdata;
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a);
    acc(1'b0, a, 32'h0);
  endtask

  task automatic cmd(input logic [3:0] op);
    acc(1'b1, FTS_OFS_CMD, {28'h0, op});
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic wait_alloc;
    int n;
    n = 0;
    while (cpu_idle !== 1'b0 && n < 60) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 60) fails++;
  endtask

  initial begin
    repeat (4000) @(posedge sys_clk);
    fails++;
    report_and_stop;
  end

  // ****
  // Tests
  // ****
  initial begin
    nrst = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    irq_req = 1'b0;
    fails = 0;
    checks_done = 0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    acc(1'b1, FTS_OFS_OPND, 32'h3);
    cmd(FTS_OP_MOV_TO_CIR);
    rd(FTS_OFS_STATUS);
    chk(v & 32'h0007_0000, 32'h0003_0000);
    cmd(FTS_OP_MOV_FROM_CIR);
    rd(FTS_OFS_RESULT);
    chk(v, 32'h3);
    acc(1'b1, FTS_OFS_OPND, 32'h0);
    cmd(FTS_OP_MOV_TO_CIR);
    $display("test set index done");
    acc(1'b1, FTS_OFS_EFFA, 32'h1000);
    acc(1'b1, FTS_OFS_OPND, 32'h2000);
    cmd(FTS_OP_PFORK);
    rd(FTS_OFS_STATUS);
    chk(v & 32'h1, 32'h1);
    cmd(FTS_OP_PFORK);
    rd(FTS_OFS_STATUS);
    chk(v & 32'h1, 32'h0);
    rd(FTS_OFS_SET_VIEW);
    chk(v & 32'h3F33, 32'h0113);
    cmd(FTS_OP_WFORK);
    wait_alloc();
    rd(FTS_OFS_CPU_PC);
    chk(v, 32'h1000);
    rd(FTS_OFS_CPU_SP);
    chk(v, 32'h2000);
    rd(FTS_OFS_STATUS);
    chk(v & 32'h0007_1F12, 32'h0);
    rd(FTS_OFS_SET_VIEW);
    chk(v & 32'h3F03, 32'h0100);
    rd(FTS_OFS_THR_MASK);
    chk(v, 32'hFFFFFFFE);
    $display("test single fork done");
    acc(1'b1, FTS_OFS_EFFA, 32'h3000);
    cmd(FTS_OP_SPAWN);
    cmd(FTS_OP_WFORK);
    wait_alloc();
    rd(FTS_OFS_CPU_PC);
    chk(v, 32'h3000);
    rd(FTS_OFS_SET_VIEW);
    chk(v & 32'h3F33, 32'h0123);
    cmd(FTS_OP_JOIN);
    rd(FTS_OFS_STATUS);
    chk(v & 32'h2, 32'h0);
    rd(FTS_OFS_SET_VIEW);
    chk(v & 32'h3, 32'h0);
    $display("test spawn and join done");
    acc(1'b1, FTS_OFS_RING, 32'h1);
    cmd(FTS_OP_IDLE);
    rd(FTS_OFS_STATUS);
    chk(v & 32'hA, 32'h8);
    acc(1'b1, FTS_OFS_RING, 32'h0);
    cmd(FTS_OP_SPAWN);
    acc(1'b1, FTS_OFS_THR_CTRL, 32'h1);
    cmd(FTS_OP_IDLE);
    repeat (40) @(posedge sys_clk);
    chk({31'h0, cpu_idle}, 32'h1);
    irq_req <= 1'b1;
    @(posedge sys_clk);
    irq_req <= 1'b0;
    wait_alloc();
    chk({31'h0, irq_taken}, 32'h1);
    $display("test idle and interrupt done");
    acc(1'b1, FTS_OFS_THR_CTRL, 32'h0);
    cmd(FTS_OP_IDLE);
    wait_alloc();
    cmd(FTS_OP_IDLE);
    wait_alloc();
    rd(FTS_OFS_STATUS);
    chk(v & 32'h1F00, 32'h0100);
    cmd(FTS_OP_JOIN);
    chk({31'h0, cpu_idle}, 32'h1);
    rd(FTS_OFS_SET_VIEW);
    chk(v & 32'h3F33, 32'h0133);
    irq_req <= 1'b1;
    @(posedge sys_clk);
    irq_req <= 1'b0;
    wait_alloc();
    chk({31'h0, irq_taken}, 32'h1);
    rd(FTS_OFS_SET_VIEW);
    chk(v & 32'h3, 32'h3);
    $display("test join halt done");
    cmd(FTS_OP_CFORK);
    rd(FTS_OFS_SET_VIEW);
    chk(v & 32'h3, 32'h0);
    acc(1'b1, FTS_OFS_THR_MASK, 32'hF0);
    acc(1'b1, FTS_OFS_EFFA, 32'h5);
    acc(1'b1, FTS_OFS_OPND, 32'h0);
    cmd(FTS_OP_STORE_SET);
    acc(1'b1, FTS_OFS_OPND, 32'h2);
    cmd(FTS_OP_LOAD_SET);
    acc(1'b1, FTS_OFS_SET_SEL, 32'h2);
    rd(FTS_OFS_THR_MASK);
    chk(v, 32'hF0);
    rd(8'h3C);
    chk(v, 32'h0);
    $display("test clear and save done");
    report_and_stop;
  end
endmodule
`default_nettype wire
